// File: hw/bpd_map.vh
// register offsets, field positions, reset values and timing counts of the
// protection and diagnostic block. assumes a 40 MHz system clock.
`ifndef BPD_MAP_VH
`define BPD_MAP_VH

// ---------------------------------------------------------------
// register offsets (word index = byte address of the plain port)
// ---------------------------------------------------------------
`define BPD_OFS_CFG       8'h00
`define BPD_OFS_PROT_EN   8'h01
`define BPD_OFS_FET_SEL   8'h02
`define BPD_OFS_POLICY    8'h03
`define BPD_OFS_STATUS    8'h04
`define BPD_OFS_CLEAR     8'h05
`define BPD_OFS_FET_STAT  8'h06
`define BPD_OFS_RETRY     8'h07
`define BPD_OFS_OW_CFG    8'h08
`define BPD_OFS_GAIN      8'h09
`define BPD_OFS_OFFSET    8'h0A
`define BPD_OFS_CHAN      8'h0B
`define BPD_OFS_RESULT    8'h0C
`define BPD_OFS_TS_DATA   8'h0D
`define BPD_OFS_STACK     8'h0E
`define BPD_OFS_PWM       8'h0F
`define BPD_OFS_RECOVER   8'h10

// ---------------------------------------------------------------
// cfg fields
// ---------------------------------------------------------------
`define BPD_CFG_TS_AUX     0
`define BPD_CFG_PARALLEL   1
`define BPD_CFG_PWM_EN     2
`define BPD_CFG_CHGDET_IE  3
`define BPD_CFG_CURR_CHG   4
`define BPD_CFG_HWOT_OFF   5
`define BPD_CFG_LDO_FET    6
`define BPD_CFG_RST        16'h0000

// ---------------------------------------------------------------
// fault bit positions in status, enable, fet select and policy
// ---------------------------------------------------------------
`define BPD_F_OCC     0
`define BPD_F_OCD1    1
`define BPD_F_OCD2    2
`define BPD_F_SCD     3
`define BPD_F_CUV     4
`define BPD_F_COV     5
`define BPD_F_TEMP    6
`define BPD_F_WDOG    7
`define BPD_F_OPEN    8
`define BPD_F_REFCHK  9
`define BPD_F_GNDCHK  10
`define BPD_F_LDO     11
`define BPD_F_LATCH   12
`define BPD_F_HWOT    13
`define BPD_NFAULT    14
`define BPD_CURR_MASK 14'h000F
`define BPD_DIAG_MASK 14'h0E00

// policy codes, two bits per fault
`define BPD_POL_AUTO  2'h0
`define BPD_POL_HOST  2'h1
`define BPD_POL_FLAG  2'h2

// ---------------------------------------------------------------
// trim, reference window, ground window
// ---------------------------------------------------------------
`define BPD_GAIN_RST    16'h4000
`define BPD_OFFSET_RST  16'h0000
`define BPD_REF_LO      16'h5A00
`define BPD_REF_HI      16'h6600
`define BPD_GND_MAX     16'h0040

// ---------------------------------------------------------------
// timing: retry delay 100 ms, open-wire base tick 1 ms, debounce 1 ms
// ---------------------------------------------------------------
`define BPD_CLK_HZ       40000000
`define BPD_RETRY_MS     100
`define BPD_RETRY_CYC    (`BPD_RETRY_MS * (`BPD_CLK_HZ / 1000))
`define BPD_OW_TICK_US   1000
`define BPD_OW_TICK_CYC  (`BPD_OW_TICK_US * (`BPD_CLK_HZ / 1000000))
`define BPD_DEB_US       1000
`define BPD_DEB_CYC      (`BPD_DEB_US * (`BPD_CLK_HZ / 1000000))

`endif

// File: hw/bpd_core.v
// protection and diagnostic fault logic of a multi-cell battery monitor.
// assumes comparator and converter results arrive synchronous to clk_sys,
// with one-cycle valid strobes; analog switches sit outside this block.
`timescale 1ns/100ps
`include "bpd_map.vh"

// Function
// - config bit selects thermistor or aux input
// - thermistor: pullup only during conversion, ldo reference
// - aux mode: pullup off, primary reference
// - pin result signed 16-bit, 5/3 full scale
// - offset/gain trim corrects cell, stack, die and current results, user writable
// - per-protection enable and fet action select
// - three recovery policies; host does its part
// - current faults from comparators, others from data
// - series/parallel fets and pwm precharge drive
// - charge pin flag, interrupt on debounced toggle
// - current fault drops discharge, maybe charge; retry
// - persisting fault after retry trips again
// - retry counter latches fets off at limit
// - periodic open-wire sink, fault cell and above
// - diagnostics trip at once; host recovers some
// - ldo versus primary reference window check
// - ground conversion compared to expected value
// - stack top voltage readable by host
// - external ldo error faults, optionally drops fets
// - oscillator failure forces power off
// - trim check error forces power off
// - hardware overtemperature may start power off
module bpd_core (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // comparator and logic fault sources
  input wire [`BPD_NFAULT-1:0] fault_raw,
  // converter results
  input wire conv_valid,
  input wire [2:0] conv_chan,
  input wire [15:0] conv_data,
  input wire ts_conv_active,
  // open wire cell readings
  input wire [4:0] cell_collapsed,
  // charge pin detector and ldo flag
  input wire chg_pin_high,
  input wire ldo_error,
  // oscillator monitor and trim check
  input wire osc_fail,
  input wire trim_check_done,
  input wire trim_check_err,
  // analog controls
  output wire ts_pullup_en,
  output wire ts_ref_ldo,
  output reg [4:0] ow_sink_en,
  output wire chg_fet_on,
  output wire dsg_fet_on,
  output wire fet_parallel,
  output wire alert,
  output reg power_off
);

  // ---------------------------------------------------------------
  // channels of the converter
  // ---------------------------------------------------------------
  localparam CH_CELL = 3'h0;
  localparam CH_STACK = 3'h1;
  localparam CH_DIE = 3'h2;
  localparam CH_CURR = 3'h3;
  localparam CH_TS = 3'h4;
  localparam CH_LDO = 3'h5;
  localparam CH_GND = 3'h6;

  localparam RS_IDLE = 2'h0;
  localparam RS_WAIT = 2'h1;
  localparam RS_LATCH = 2'h2;

  localparam [31:0] RETRY_CYC = `BPD_RETRY_CYC;
  localparam [31:0] OW_TICK_FULL = `BPD_OW_TICK_CYC;
  localparam [31:0] DEB_FULL = `BPD_DEB_CYC;
  // both counts fit 16 bits at 40 MHz; the cut is deliberate
  localparam [15:0] OW_TICK_CYC = OW_TICK_FULL[15:0];
  localparam [15:0] DEB_CYC = DEB_FULL[15:0];
  localparam [13:0] DIAG_MASK = `BPD_DIAG_MASK;
  localparam [13:0] CURR_MASK = `BPD_CURR_MASK;

  reg [15:0] cfg_reg;
  reg [13:0] en_reg;
  reg [13:0] fet_sel_reg;
  reg [27:0] policy_reg;
  reg [13:0] status_reg;
  reg [13:0] status_next;
  reg [15:0] gain_reg;
  reg [15:0] offset_reg;
  reg [3:0] retry_limit_reg;
  reg [3:0] retry_cnt_reg;
  reg [7:0] ow_period_reg;
  reg [15:0] result_reg;
  reg [2:0] result_chan_reg;
  reg [15:0] ts_data_reg;
  reg [15:0] stack_reg;
  reg [7:0] pwm_duty_reg;
  reg [7:0] pwm_cnt_reg;
  reg [1:0] rs_state_reg;
  reg [31:0] rs_cnt_reg;
  reg chg_off_reg;
  reg dsg_off_reg;
  reg [15:0] ow_tick_reg;
  reg [7:0] ow_div_reg;
  reg [15:0] deb_cnt_reg;
  reg chg_deb_reg;
  reg chgdet_ev_reg;

  // ---------------------------------------------------------------
  // temperature pin mode
  // ---------------------------------------------------------------
  wire ts_aux = cfg_reg[`BPD_CFG_TS_AUX];
  assign ts_pullup_en = ts_conv_active & ~ts_aux;
  assign ts_ref_ldo = ~ts_aux;
  assign fet_parallel = cfg_reg[`BPD_CFG_PARALLEL];

  // ---------------------------------------------------------------
  // trim: signed offset then gain in q2.14
  // ---------------------------------------------------------------
  wire signed [16:0] trim_sum = $signed({conv_data[15], conv_data}) +
                                $signed({offset_reg[15], offset_reg});
  wire signed [33:0] trim_prod = trim_sum * $signed({1'b0, gain_reg});
  wire signed [19:0] trim_q = trim_prod[33:14];
  wire [15:0] trim_sat = (trim_q > 20'sh07FFF) ? 16'h7FFF :
                         (trim_q < -20'sh08000) ? 16'h8000 : trim_q[15:0];
  wire trimmed = (conv_chan == CH_CELL) | (conv_chan == CH_STACK) |
                 (conv_chan == CH_DIE) | (conv_chan == CH_CURR);
  wire [15:0] conv_out = trimmed ? trim_sat : conv_data;

  // ---------------------------------------------------------------
  // diagnostic detection, immediate
  // ---------------------------------------------------------------
  wire ref_bad = conv_valid & (conv_chan == CH_LDO) &
                 ((conv_data < `BPD_REF_LO) | (conv_data > `BPD_REF_HI));
  wire gnd_bad = conv_valid & (conv_chan == CH_GND) &
                 ($signed(conv_data) > $signed(`BPD_GND_MAX) |
                  $signed(conv_data) < -$signed(`BPD_GND_MAX));
  wire ow_bad = |(cell_collapsed & ow_sink_en);

  // comparator faults and logic faults enter on fault_raw
  reg [13:0] fault_now;
  always @* begin
    fault_now = fault_raw;
    fault_now[`BPD_F_OPEN] = fault_raw[`BPD_F_OPEN] | ow_bad;
    fault_now[`BPD_F_REFCHK] = ref_bad;
    fault_now[`BPD_F_GNDCHK] = gnd_bad;
    fault_now[`BPD_F_LDO] = ldo_error;
    fault_now[`BPD_F_LATCH] = (rs_state_reg == RS_LATCH);
    fault_now = fault_now & en_reg;
  end
  // level, not edge: a fault still present after a retry trips again
  wire [13:0] cur_lvl = fault_now & CURR_MASK;

  // ---------------------------------------------------------------
  // status: set wins over clear; auto policy clears on recovery, except the diagnostic bits
  // ---------------------------------------------------------------
  wire clr_wr = reg_wr & (reg_addr == `BPD_OFS_CLEAR);
  wire rec_wr = reg_wr & (reg_addr == `BPD_OFS_RECOVER);
  integer i;
  always @* begin
    status_next = status_reg;
    for (i = 0; i < `BPD_NFAULT; i = i + 1) begin
      if (policy_reg[2*i +: 2] == `BPD_POL_AUTO && !fault_now[i] &&
          !DIAG_MASK[i]) begin
        status_next[i] = 1'b0;
      end
      if (clr_wr && reg_wdata[i]) begin
        status_next[i] = 1'b0;
      end
      if (rec_wr && reg_wdata[i]) begin
        status_next[i] = 1'b0;
      end
      if (fault_now[i]) begin
        status_next[i] = 1'b1;
      end
    end
  end

  // faults that act on the fets autonomously (not signal-only)
  reg [13:0] act_mask;
  reg [13:0] host_mask;
  integer j;
  always @* begin
    act_mask = 14'h0000;
    host_mask = 14'h0000;
    for (j = 0; j < `BPD_NFAULT; j = j + 1) begin
      act_mask[j] = fet_sel_reg[j] & (policy_reg[2*j +: 2] != `BPD_POL_FLAG);
      host_mask[j] = (policy_reg[2*j +: 2] == `BPD_POL_HOST);
    end
  end
  wire [13:0] act_stat = status_reg & act_mask & ~CURR_MASK;
  wire ldo_drop = status_reg[`BPD_F_LDO] & cfg_reg[`BPD_CFG_LDO_FET];
  // latch bit left out: the retry logic already holds what it dropped, and
  // counting it here would drop the charge fet against the cfg choice
  wire [13:0] keep_mask = ~((14'h0001 << `BPD_F_LDO) | (14'h0001 << `BPD_F_LATCH));
  wire other_off = |(act_stat & keep_mask) | ldo_drop;
  wire cur_act = |(cur_lvl & act_mask);
  wire cur_auto = ~|(cur_lvl & act_mask & host_mask);

  // ---------------------------------------------------------------
  // pwm precharge drive
  // ---------------------------------------------------------------
  wire pwm_on = cfg_reg[`BPD_CFG_PWM_EN] ? (pwm_cnt_reg < pwm_duty_reg) : 1'b1;
  assign dsg_fet_on = ~dsg_off_reg & ~other_off & ~power_off & pwm_on;
  assign chg_fet_on = ~chg_off_reg & ~other_off & ~power_off & pwm_on;

  // ---------------------------------------------------------------
  // charge pin detector and alert
  // ---------------------------------------------------------------
  assign alert = chgdet_ev_reg;

  // ---------------------------------------------------------------
  // clocked state
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= `BPD_CFG_RST;
      en_reg <= 14'h3FFF;
      fet_sel_reg <= 14'h3FFF;
      policy_reg <= 28'h0000000;
      status_reg <= 14'h0000;
      gain_reg <= `BPD_GAIN_RST;
      offset_reg <= `BPD_OFFSET_RST;
      retry_limit_reg <= 4'h3;
      retry_cnt_reg <= 4'h0;
      ow_period_reg <= 8'h00;
      result_reg <= 16'h0000;
      result_chan_reg <= 3'h0;
      ts_data_reg <= 16'h0000;
      stack_reg <= 16'h0000;
      pwm_duty_reg <= 8'h80;
      pwm_cnt_reg <= 8'h00;
      rs_state_reg <= RS_IDLE;
      rs_cnt_reg <= 32'h00000000;
      chg_off_reg <= 1'b0;
      dsg_off_reg <= 1'b0;
      ow_tick_reg <= 16'h0000;
      ow_div_reg <= 8'h00;
      ow_sink_en <= 5'h00;
      deb_cnt_reg <= 16'h0000;
      chg_deb_reg <= 1'b0;
      chgdet_ev_reg <= 1'b0;
      power_off <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      status_reg <= status_next;
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;

      // register writes
      if (reg_wr) begin
        case (reg_addr)
          `BPD_OFS_CFG: cfg_reg <= reg_wdata;
          `BPD_OFS_PROT_EN: en_reg <= reg_wdata[13:0];
          `BPD_OFS_FET_SEL: fet_sel_reg <= reg_wdata[13:0];
          `BPD_OFS_POLICY: policy_reg <= {policy_reg[27:16], reg_wdata};
          `BPD_OFS_RETRY: retry_limit_reg <= reg_wdata[3:0];
          `BPD_OFS_OW_CFG: ow_period_reg <= reg_wdata[7:0];
          `BPD_OFS_GAIN: gain_reg <= reg_wdata;
          `BPD_OFS_OFFSET: offset_reg <= reg_wdata;
          `BPD_OFS_PWM: pwm_duty_reg <= reg_wdata[7:0];
          default: policy_reg <= policy_reg;
        endcase
      end

      // register reads, data in the next cycle
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `BPD_OFS_CFG: reg_rdata <= cfg_reg;
          `BPD_OFS_PROT_EN: reg_rdata <= {2'h0, en_reg};
          `BPD_OFS_FET_SEL: reg_rdata <= {2'h0, fet_sel_reg};
          `BPD_OFS_POLICY: reg_rdata <= policy_reg[15:0];
          `BPD_OFS_STATUS: reg_rdata <= {2'h0, status_reg};
          `BPD_OFS_FET_STAT: reg_rdata <= {10'h000, chg_pin_high, chg_deb_reg,
                                           power_off, rs_state_reg == RS_LATCH,
                                           chg_fet_on, dsg_fet_on};
          `BPD_OFS_RETRY: reg_rdata <= {8'h00, retry_cnt_reg, retry_limit_reg};
          `BPD_OFS_OW_CFG: reg_rdata <= {8'h00, ow_period_reg};
          `BPD_OFS_GAIN: reg_rdata <= gain_reg;
          `BPD_OFS_OFFSET: reg_rdata <= offset_reg;
          `BPD_OFS_CHAN: reg_rdata <= {13'h0000, result_chan_reg};
          `BPD_OFS_RESULT: reg_rdata <= result_reg;
          `BPD_OFS_TS_DATA: reg_rdata <= ts_data_reg;
          `BPD_OFS_STACK: reg_rdata <= stack_reg;
          `BPD_OFS_PWM: reg_rdata <= {8'h00, pwm_duty_reg};
          default: reg_rdata <= 16'h0000;
        endcase
      end

      // conversion capture
      if (conv_valid) begin
        result_reg <= conv_out;
        result_chan_reg <= conv_chan;
        if (conv_chan == CH_TS) begin
          ts_data_reg <= conv_data;
        end
        if (conv_chan == CH_STACK) begin
          stack_reg <= conv_out;
        end
      end

      // current fault retry and latch
      case (rs_state_reg)
        RS_IDLE: begin
          if (cur_act) begin
            dsg_off_reg <= 1'b1;
            chg_off_reg <= cfg_reg[`BPD_CFG_CURR_CHG];
            rs_cnt_reg <= 32'h00000000;
            if (!cur_auto) begin
              rs_state_reg <= RS_LATCH;
            end else if (retry_cnt_reg >= retry_limit_reg) begin
              rs_state_reg <= RS_LATCH;
            end else begin
              rs_state_reg <= RS_WAIT;
            end
          end
        end
        RS_WAIT: begin
          if (rs_cnt_reg >= RETRY_CYC - 32'h1) begin
            dsg_off_reg <= 1'b0;
            chg_off_reg <= 1'b0;
            retry_cnt_reg <= retry_cnt_reg + 4'h1;
            rs_state_reg <= RS_IDLE;
          end else begin
            rs_cnt_reg <= rs_cnt_reg + 32'h1;
          end
        end
        RS_LATCH: begin
          if (rec_wr && reg_wdata[`BPD_F_LATCH]) begin
            dsg_off_reg <= 1'b0;
            chg_off_reg <= 1'b0;
            retry_cnt_reg <= 4'h0;
            rs_state_reg <= RS_IDLE;
          end
        end
        default: rs_state_reg <= RS_IDLE;
      endcase

      // open-wire sink, period in 1 ms ticks, zero disables
      ow_sink_en <= 5'h00;
      if (ow_period_reg != 8'h00) begin
        if (ow_tick_reg >= OW_TICK_CYC - 16'h1) begin
          ow_tick_reg <= 16'h0000;
          if (ow_div_reg >= ow_period_reg - 8'h1) begin
            ow_div_reg <= 8'h00;
          end else begin
            ow_div_reg <= ow_div_reg + 8'h01;
          end
        end else begin
          ow_tick_reg <= ow_tick_reg + 16'h0001;
        end
        if (ow_div_reg == 8'h00) begin
          ow_sink_en <= 5'h1F;
        end
      end

      // charge pin debounce, alert pulse on toggle
      chgdet_ev_reg <= 1'b0;
      if (chg_pin_high == chg_deb_reg) begin
        deb_cnt_reg <= 16'h0000;
      end else if (deb_cnt_reg >= DEB_CYC - 16'h1) begin
        deb_cnt_reg <= 16'h0000;
        chg_deb_reg <= chg_pin_high;
        chgdet_ev_reg <= cfg_reg[`BPD_CFG_CHGDET_IE];
      end else begin
        deb_cnt_reg <= deb_cnt_reg + 16'h0001;
      end

      // power off sources; only reset leaves this state
      if (osc_fail) begin
        power_off <= 1'b1;
      end
      if (trim_check_done && trim_check_err) begin
        power_off <= 1'b1;
      end
      if (fault_raw[`BPD_F_HWOT] && cfg_reg[`BPD_CFG_HWOT_OFF]) begin
        power_off <= 1'b1;
      end
    end
  end

endmodule

// File: bench/bpd_core_monitor.sv
// port checker of the protection and diagnostic block.
// assumes one clock and a bind from the testbench top; sees ports only.
`timescale 1ns/100ps
module bpd_core_monitor (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // sources
  input wire ts_conv_active,
  input wire osc_fail,
  input wire trim_check_done,
  input wire trim_check_err,
  // controls
  input wire ts_pullup_en,
  input wire ts_ref_ldo,
  input wire alert,
  input wire power_off
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ------------------------------
  // temperature pin
  // ------------------------------
  a_pullup_gate: assert property (ts_pullup_en |-> ts_conv_active && ts_ref_ldo)
    else $error("pullup on outside a thermistor conversion");
  a_pullup_on: assert property (ts_conv_active && ts_ref_ldo |-> ts_pullup_en)
    else $error("pullup off during a thermistor conversion");
  a_mode_write: assert property ($changed(ts_ref_ldo) |-> $past(reg_wr) && $past(reg_addr) == 8'h00)
    else $error("reference choice changed without a config write");

  // ------------------------------
  // bus, power off, alert
  // ------------------------------
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  a_power_hold: assert property (power_off |=> power_off)
    else $error("power off released without reset");
  a_osc_off: assert property (osc_fail |-> ##[1:3] power_off)
    else $error("oscillator failure did not power off");
  a_trim_off: assert property (trim_check_done && trim_check_err |-> ##[1:3] power_off)
    else $error("trim check error did not power off");
  a_alert_pulse: assert property (alert |=> !alert)
    else $error("alert longer than one cycle");
endmodule

// File: bench/bpd_host_model.sv
// pack-side host processor model: master of the plain register port.
// assumes the slave answers a read in the next cycle and never stalls.
`timescale 1ns/100ps
module bpd_host_model (
  // clock
  input wire clk_sys,
  // register port
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_wr = 1'h0,
  output logic reg_rd = 1'h0,
  input wire [15:0] reg_rdata
);
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  // sticky faults are cleared first so the latch release is not undone
  task recover(input logic [15:0] mask);
    wr(8'h05, mask);
    wr(8'h10, 16'h1000);
  endtask
endmodule

// File: bench/tb_battery_protection_diagnostics.sv
// top testbench of the protection block: host model, bound checker,
// table of pin mode cases, then hand-written fault and power-off cases.
`timescale 1ns/100ps
`include "bpd_map.vh"
module tb_battery_protection_diagnostics;
  typedef struct {logic [15:0] cfg; logic act; logic [2:0] exp;} bpd_row_t;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic reg_wr, reg_rd, conv_valid = 1'h0, ts_conv_active = 1'h0;
  logic [`BPD_NFAULT-1:0] fault_raw = '0;
  logic [2:0] conv_chan = 3'h0;
  logic [15:0] conv_data = 16'h0000;
  logic chg_pin_high = 1'h0, ldo_error = 1'h0, osc_fail = 1'h0;
  logic trim_check_done = 1'h0, trim_check_err = 1'h0;
  logic ts_pullup_en, ts_ref_ldo, chg_fet_on, dsg_fet_on, fet_parallel, alert, power_off;
  logic [4:0] ow_sink_en, cell_collapsed = 5'h00;
  int err_count = 0, compares = 0;
  logic [23:0] rv [9] = '{24'h000000, 24'h013FFF, 24'h023FFF, 24'h040000, 24'h060003,
    24'h070003, 24'h094000, 24'h0A0000, 24'h200000};
  bpd_row_t rows [4] = '{'{16'h0000, 1'h1, 3'h6}, '{16'h0000, 1'h0, 3'h2},
    '{16'h0001, 1'h1, 3'h0}, '{16'h0002, 1'h1, 3'h7}};

  always #12.5 clk_sys = ~clk_sys;

  bpd_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  bpd_core uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault_raw(fault_raw), .conv_valid(conv_valid), .conv_chan(conv_chan),
    .conv_data(conv_data), .ts_conv_active(ts_conv_active), .cell_collapsed(cell_collapsed),
    .chg_pin_high(chg_pin_high), .ldo_error(ldo_error), .osc_fail(osc_fail),
    .trim_check_done(trim_check_done), .trim_check_err(trim_check_err),
    .ts_pullup_en(ts_pullup_en), .ts_ref_ldo(ts_ref_ldo), .ow_sink_en(ow_sink_en),
    .chg_fet_on(chg_fet_on), .dsg_fet_on(dsg_fet_on), .fet_parallel(fet_parallel),
    .alert(alert), .power_off(power_off));

  // ------------------------------
  // helpers
  // ------------------------------
  task report_and_stop;
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? dsg_fet_on : (s == 1 ? power_off : alert);
  endfunction

  // bounded wait; a limit that runs out shows up as a mismatch
  task wait_out(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("awaited output", {15'h0, lvl}, {15'h0, pick(s)});
    if (pick(s) !== lvl)
      report_and_stop;
  endtask

  task conv(input logic [2:0] ch, input logic [15:0] d);
    @(posedge clk_sys);
    conv_valid <= 1'h1;
    conv_chan <= ch;
    conv_data <= d;
    @(posedge clk_sys);
    conv_valid <= 1'h0;
  endtask

  task do_reset(input logic bad);
    @(posedge clk_sys);
    arst_n <= 1'h0;
    trim_check_done <= 1'h0;
    trim_check_err <= 1'h0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    trim_check_done <= 1'h1;
    trim_check_err <= bad;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    do_reset(1'h0);
    host.wr(8'h04, 16'hFFFF);
    foreach (rv[i]) begin
      host.rd(rv[i][23:16], rd_val);
      chk("reset value", rv[i][15:0], rd_val);
    end
    foreach (rows[i]) begin
      host.wr(8'h00, rows[i].cfg);
      @(posedge clk_sys);
      ts_conv_active <= rows[i].act;
      @(posedge clk_sys);
      #1;
      chk("pin mode", {13'h0, rows[i].exp}, {13'h0, ts_pullup_en, ts_ref_ldo, fet_parallel});
    end
    host.wr(8'h00, 16'h0000);
    host.wr(8'h09, 16'h6000);
    host.wr(8'h0A, 16'h0010);
    conv(3'h1, 16'h0100);
    host.rd(8'h0E, rd_val);
    chk("stack", 16'h0198, rd_val);
    conv(3'h4, 16'h8123);
    host.rd(8'h0D, rd_val);
    chk("pin raw", 16'h8123, rd_val);
    conv(3'h6, 16'h0040);
    conv(3'h5, 16'h5A00);
    conv(3'h5, 16'h6600);
    host.rd(8'h04, rd_val);
    chk("window edges", 16'h0000, rd_val & 16'h0E00);
    conv(3'h6, 16'h0041);
    wait_out(0, 1'h0, 20);
    conv(3'h5, 16'h59FF);
    ldo_error <= 1'h1;
    host.rd(8'h04, rd_val);
    chk("diag faults", 16'h0E00, rd_val & 16'h0E00);
    @(posedge clk_sys);
    ldo_error <= 1'h0;
    host.recover(16'h0E00);
    wait_out(0, 1'h1, 20);
    host.wr(8'h08, 16'h0002);
    cell_collapsed <= 5'h04;
    wait_out(0, 1'h0, 20);
    chk("ow_sink_en", 16'h001F, {11'h000, ow_sink_en});
    @(posedge clk_sys);
    cell_collapsed <= 5'h00;
    wait_out(0, 1'h1, 20);
    host.wr(8'h08, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("ow_sink_en", 16'h0000, {11'h000, ow_sink_en});
    host.wr(8'h0F, 16'h0000);
    host.wr(8'h00, 16'h0004);
    wait_out(0, 1'h0, 4);
    host.wr(8'h00, 16'h0000);
    wait_out(0, 1'h1, 4);
    host.wr(8'h07, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      host.wr(8'h00, i[0] ? 16'h0010 : 16'h0000);
      host.wr(8'h03, i[0] ? 16'h0000 : 16'h0040);
      @(posedge clk_sys);
      fault_raw[3] <= 1'h1;
      wait_out(0, 1'h0, 20);
      chk("chg_fet_on", {15'h0, ~i[0]}, {15'h0, chg_fet_on});
      @(posedge clk_sys);
      fault_raw[3] <= 1'h0;
      repeat (20) @(posedge clk_sys);
      #1;
      chk("held off", 16'h0000, {15'h0, dsg_fet_on});
      chk("chg held", {15'h0, ~i[0]}, {15'h0, chg_fet_on});
      host.recover(16'h1008);
      wait_out(0, 1'h1, 20);
    end
    host.wr(8'h03, 16'h0080);
    @(posedge clk_sys);
    fault_raw[3] <= 1'h1;
    host.rd(8'h04, rd_val);
    chk("flag status", 16'h0008, rd_val & 16'h0008);
    chk("flag fets", 16'h0001, {15'h0, dsg_fet_on});
    host.wr(8'h01, 16'h3FF7);
    host.recover(16'h0008);
    host.rd(8'h04, rd_val);
    chk("disabled", 16'h0000, rd_val & 16'h0008);
    @(posedge clk_sys);
    fault_raw[3] <= 1'h0;
    for (int s = 0; s < 3; s++) begin
      do_reset(s == 1);
      if (s == 2)
        host.wr(8'h00, 16'h0020);
      @(posedge clk_sys);
      osc_fail <= (s == 0);
      fault_raw[13] <= (s == 2);
      wait_out(1, 1'h1, 50);
      @(posedge clk_sys);
      osc_fail <= 1'h0;
      fault_raw[13] <= 1'h0;
    end
    do_reset(1'h0);
    host.wr(8'h00, 16'h0008);
    @(posedge clk_sys);
    chg_pin_high <= 1'h1;
    wait_out(2, 1'h1, 45000);
    host.rd(8'h06, rd_val);
    chk("chg detect", 16'h0030, rd_val & 16'h0030);
    report_and_stop;
  end

  initial begin
    #(90000 * 25);
    err_count++;
    report_and_stop;
  end
endmodule

bind bpd_core bpd_core_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ts_conv_active(ts_conv_active), .osc_fail(osc_fail), .trim_check_done(trim_check_done),
  .trim_check_err(trim_check_err), .ts_pullup_en(ts_pullup_en), .ts_ref_ldo(ts_ref_ldo),
  .alert(alert), .power_off(power_off));
